// ===== src/hem_mailbox.sv
module hem_mailbox (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  host_addr_i,
  input  wire logic        host_wr_i,
  input  wire logic        host_rd_i,
  input  wire logic [7:0]  host_wdata_i,
  output logic      [7:0]  host_rdata_o,
  input  wire logic [31:0] ctrl_addr_i,
  input  wire logic        ctrl_wr_i,
  input  wire logic        ctrl_rd_i,
  input  wire logic [31:0] ctrl_wdata_i,
  output logic      [31:0] ctrl_rdata_o,
  output logic             host_fw_event_irq_o,
  output logic             host_mbox_irq_o,
  output logic             ctrl_mbox_event_o
);
  import hem_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  h2c;
    logic [7:0]  c2h;
    logic [15:0] src;
    logic [7:0]  mask_lo;
    logic [7:0]  mask_hi;
    logic [7:0]  claim_id;
    logic [31:0] w0_base;
    logic [15:0] w0_rlim;
    logic [15:0] w0_wlim;
    logic [31:0] w1_base;
    logic [15:0] w1_rlim;
    logic [15:0] w1_wlim;
    logic [15:0] clr_en;
    logic [7:0]  host_rdata;
    logic [31:0] ctrl_rdata;
    logic        fw_irq;
    logic        mbox_irq;
    logic        ctrl_evt;
  } hem_state_t;

  hem_state_t st_q;
  hem_state_t st_d;

  function automatic logic ctrl_hit(input logic [31:0] a, input logic [31:0] off);
    return a == CTRL_BASE + off;
  endfunction

  function automatic logic host_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic hw;
    logic cw;
    hw = host_wr_i;
    cw = ctrl_wr_i;
    st_d = st_q;
    st_d.ctrl_evt = 1'b0;

    // host writes first, controller writes after, except h2c where the host write comes last: later assignment wins
    if (hw && host_hit(host_addr_i, HOST_C2H_MBOX)) begin
      st_d.c2h = st_q.c2h & ~host_wdata_i;
      st_d.src[FLAG_BIT] = 1'b0;
    end
    if (hw && host_hit(host_addr_i, HOST_SRC_LOW)) begin
      st_d.src[7:0] = st_q.src[7:0] & ~(host_wdata_i & st_q.clr_en[7:0] & FW_EVENT_MASK[7:0]);
    end
    if (hw && host_hit(host_addr_i, HOST_SRC_HIGH)) begin
      st_d.src[15:8] = st_q.src[15:8] & ~(host_wdata_i & st_q.clr_en[15:8]);
    end
    if (hw && host_hit(host_addr_i, HOST_MASK_LOW)) begin
      st_d.mask_lo = host_wdata_i;
    end
    if (hw && host_hit(host_addr_i, HOST_MASK_HIGH)) begin
      st_d.mask_hi = host_wdata_i;
    end
    if (hw && host_hit(host_addr_i, HOST_CLAIM_ID)) begin
      if (st_q.claim_id == ZERO_BYTE) begin
        st_d.claim_id = host_wdata_i;
      end else if (host_wdata_i == st_q.claim_id) begin
        st_d.claim_id = ZERO_BYTE;
      end
      // differing value while claimed: no change
    end

    // controller clears mailbox bits, host write afterwards takes the byte
    if (cw && ctrl_hit(ctrl_addr_i, CTRL_H2C_MBOX)) begin
      st_d.h2c = st_q.h2c & ~ctrl_wdata_i[7:0];
    end
    if (hw && host_hit(host_addr_i, HOST_H2C_MBOX)) begin
      st_d.h2c = host_wdata_i;
      st_d.ctrl_evt = 1'b1;
    end
    if (cw && ctrl_hit(ctrl_addr_i, CTRL_C2H_MBOX)) begin
      st_d.c2h = ctrl_wdata_i[7:0];
      st_d.src[FLAG_BIT] = 1'b1;
    end
    if (cw && ctrl_hit(ctrl_addr_i, CTRL_EVT_SET)) begin
      // set after the host clear so a same-cycle event is not lost
      st_d.src = st_d.src | (ctrl_wdata_i[15:0] & FW_EVENT_MASK);
    end
    if (cw && ctrl_hit(ctrl_addr_i, CTRL_CLR_EN)) begin
      st_d.clr_en = ctrl_wdata_i[15:0];
    end
    if (cw && ctrl_hit(ctrl_addr_i, CTRL_W0_BASE)) begin
      st_d.w0_base = ctrl_wdata_i & BASE_MASK;
    end
    if (cw && ctrl_hit(ctrl_addr_i, CTRL_W0_RLIM)) begin
      st_d.w0_rlim = ctrl_wdata_i[15:0] & LIMIT_MASK;
    end
    if (cw && ctrl_hit(ctrl_addr_i, CTRL_W0_WLIM)) begin
      st_d.w0_wlim = ctrl_wdata_i[15:0] & LIMIT_MASK;
    end
    if (cw && ctrl_hit(ctrl_addr_i, CTRL_W1_BASE)) begin
      st_d.w1_base = ctrl_wdata_i & BASE_MASK;
    end
    if (cw && ctrl_hit(ctrl_addr_i, CTRL_W1_RLIM)) begin
      st_d.w1_rlim = ctrl_wdata_i[15:0] & LIMIT_MASK;
    end
    if (cw && ctrl_hit(ctrl_addr_i, CTRL_W1_WLIM)) begin
      st_d.w1_wlim = ctrl_wdata_i[15:0] & LIMIT_MASK;
    end

    // interrupts registered from next state so outputs stay flop-driven
    st_d.fw_irq = |((st_d.src & FW_EVENT_MASK) & {st_d.mask_hi, st_d.mask_lo});
    st_d.mbox_irq = st_d.src[FLAG_BIT] & st_d.mask_lo[FLAG_BIT];

    // read data: unmapped addresses return zero
    st_d.host_rdata = ZERO_BYTE;
    if (host_rd_i) begin
      unique case (1'b1)
        host_hit(host_addr_i, HOST_H2C_MBOX):  st_d.host_rdata = st_q.h2c;
        host_hit(host_addr_i, HOST_C2H_MBOX):  st_d.host_rdata = st_q.c2h;
        host_hit(host_addr_i, HOST_SRC_LOW):   st_d.host_rdata = st_q.src[7:0];
        host_hit(host_addr_i, HOST_SRC_HIGH):  st_d.host_rdata = st_q.src[15:8];
        host_hit(host_addr_i, HOST_MASK_LOW):  st_d.host_rdata = st_q.mask_lo;
        host_hit(host_addr_i, HOST_MASK_HIGH): st_d.host_rdata = st_q.mask_hi;
        host_hit(host_addr_i, HOST_CLAIM_ID):  st_d.host_rdata = st_q.claim_id;
        default:                               st_d.host_rdata = ZERO_BYTE;
      endcase
    end
    st_d.ctrl_rdata = '0;
    if (ctrl_rd_i) begin
      unique case (1'b1)
        ctrl_hit(ctrl_addr_i, CTRL_H2C_MBOX): st_d.ctrl_rdata = {24'h00_0000, st_q.h2c};
        ctrl_hit(ctrl_addr_i, CTRL_C2H_MBOX): st_d.ctrl_rdata = {24'h00_0000, st_q.c2h};
        ctrl_hit(ctrl_addr_i, CTRL_W0_BASE):  st_d.ctrl_rdata = st_q.w0_base;
        ctrl_hit(ctrl_addr_i, CTRL_W0_RLIM):  st_d.ctrl_rdata = {16'h0000, st_q.w0_rlim};
        ctrl_hit(ctrl_addr_i, CTRL_W0_WLIM):  st_d.ctrl_rdata = {16'h0000, st_q.w0_wlim};
        ctrl_hit(ctrl_addr_i, CTRL_W1_BASE):  st_d.ctrl_rdata = st_q.w1_base;
        ctrl_hit(ctrl_addr_i, CTRL_W1_RLIM):  st_d.ctrl_rdata = {16'h0000, st_q.w1_rlim};
        ctrl_hit(ctrl_addr_i, CTRL_W1_WLIM):  st_d.ctrl_rdata = {16'h0000, st_q.w1_wlim};
        ctrl_hit(ctrl_addr_i, CTRL_EVT_SET):  st_d.ctrl_rdata = {16'h0000, st_q.src};
        ctrl_hit(ctrl_addr_i, CTRL_CLR_EN):   st_d.ctrl_rdata = {16'h0000, st_q.clr_en};
        default:                              st_d.ctrl_rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign host_rdata_o        = st_q.host_rdata;
  assign ctrl_rdata_o        = st_q.ctrl_rdata;
  assign host_fw_event_irq_o = st_q.fw_irq;
  assign host_mbox_irq_o     = st_q.mbox_irq;
  assign ctrl_mbox_event_o   = st_q.ctrl_evt;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence seq_id_write;
    host_wr_i && host_addr_i == HOST_CLAIM_ID;
  endsequence

  sequence seq_h2c_host_write;
    host_wr_i && host_addr_i == HOST_H2C_MBOX;
  endsequence

  AST_IRQ_LOW: assert property ((st_q.mask_hi == ZERO_BYTE) |->
    host_fw_event_irq_o == |(st_q.src[7:1] & st_q.mask_lo[7:1]))
    else $error("low event gating wrong");
  AST_IRQ_HIGH: assert property ((st_q.mask_lo[7:1] == 7'h00) |->
    host_fw_event_irq_o == |(st_q.src[15:8] & st_q.mask_hi))
    else $error("high event gating wrong");
  AST_MBOX_IRQ: assert property (host_mbox_irq_o == (st_q.src[FLAG_BIT] && st_q.mask_lo[FLAG_BIT]))
    else $error("mailbox interrupt gating wrong");
  AST_ID_CLAIM: assert property (seq_id_write and (st_q.claim_id == ZERO_BYTE) |=>
    st_q.claim_id == $past(host_wdata_i))
    else $error("claim not stored");
  AST_ID_RELEASE: assert property (seq_id_write and (st_q.claim_id != ZERO_BYTE)
    and (host_wdata_i == st_q.claim_id) |=> st_q.claim_id == ZERO_BYTE)
    else $error("claim not released");
  AST_ID_HOLD: assert property (seq_id_write and (st_q.claim_id != ZERO_BYTE)
    and (host_wdata_i != st_q.claim_id) |=> $stable(st_q.claim_id))
    else $error("claim changed by foreign value");
  AST_H2C_EVENT: assert property (seq_h2c_host_write |=>
    ctrl_mbox_event_o && st_q.h2c == $past(host_wdata_i) ##1 !ctrl_mbox_event_o || $past(host_wr_i))
    else $error("mailbox write not signalled");
  AST_FLAG_SET: assert property (ctrl_wr_i && ctrl_addr_i == CTRL_BASE + CTRL_C2H_MBOX |=>
    st_q.src[FLAG_BIT] && st_q.c2h == $past(ctrl_wdata_i[7:0]))
    else $error("mailbox written flag not set");
  AST_CLR_LOCK: assert property (host_wr_i && host_addr_i == HOST_SRC_HIGH
    && !st_q.clr_en[8] && st_q.src[8] |=> st_q.src[8])
    else $error("locked event bit cleared");

  // ---------------------------------------------------------------
  // helper nets for checks
  // ---------------------------------------------------------------
  // kept as nets so each past value is of a plain signal
  logic [7:0] clr_lo_sel;
  logic [7:0] clr_hi_sel;
  logic [7:0] keep_lo;
  logic [7:0] keep_hi;
  assign clr_lo_sel = host_wdata_i & st_q.clr_en[7:0] & FW_EVENT_MASK[7:0];
  assign clr_hi_sel = host_wdata_i & st_q.clr_en[15:8];
  assign keep_lo    = st_q.src[7:0] & ~clr_lo_sel & FW_EVENT_MASK[7:0];
  assign keep_hi    = st_q.src[15:8] & ~clr_hi_sel;

  sequence seq_h2c_ctrl_clear;
    ctrl_wr_i && ctrl_addr_i == CTRL_BASE + CTRL_H2C_MBOX
      && !(host_wr_i && host_addr_i == HOST_H2C_MBOX);
  endsequence

  // a same-cycle set wins, so clears are only checked without one
  sequence seq_src_low_write;
    host_wr_i && host_addr_i == HOST_SRC_LOW
      && !(ctrl_wr_i && ctrl_addr_i == CTRL_BASE + CTRL_EVT_SET);
  endsequence

  sequence seq_src_high_write;
    host_wr_i && host_addr_i == HOST_SRC_HIGH
      && !(ctrl_wr_i && ctrl_addr_i == CTRL_BASE + CTRL_EVT_SET);
  endsequence

  sequence seq_c2h_ctrl_write;
    ctrl_wr_i && ctrl_addr_i == CTRL_BASE + CTRL_C2H_MBOX;
  endsequence

  sequence seq_c2h_host_clear;
    host_wr_i && host_addr_i == HOST_C2H_MBOX
      && !(ctrl_wr_i && ctrl_addr_i == CTRL_BASE + CTRL_C2H_MBOX);
  endsequence

  sequence seq_evt_set_write;
    ctrl_wr_i && ctrl_addr_i == CTRL_BASE + CTRL_EVT_SET;
  endsequence

  AST_H2C_CLEAR: assert property (seq_h2c_ctrl_clear |=>
    st_q.h2c == ($past(st_q.h2c) & ~$past(ctrl_wdata_i[7:0])))
    else $error("controller mailbox clear wrong");
  AST_H2C_HOST_VIEW: assert property (host_rd_i && host_addr_i == HOST_H2C_MBOX |=>
    host_rdata_o == $past(st_q.h2c))
    else $error("host view of mailbox wrong");
  AST_H2C_CTRL_VIEW: assert property (ctrl_rd_i && ctrl_addr_i == CTRL_BASE + CTRL_H2C_MBOX |=>
    ctrl_rdata_o == {24'h00_0000, $past(st_q.h2c)})
    else $error("controller view of mailbox wrong");
  AST_H2C_STABLE: assert property (!(host_wr_i && host_addr_i == HOST_H2C_MBOX)
    && !(ctrl_wr_i && ctrl_addr_i == CTRL_BASE + CTRL_H2C_MBOX) |=> $stable(st_q.h2c))
    else $error("mailbox changed without a write");
  AST_DECODE_MISS: assert property (ctrl_rd_i && (ctrl_addr_i - CTRL_BASE) > CTRL_CLR_EN |=>
    ctrl_rdata_o == '0)
    else $error("read outside the block answered");
  AST_EVT_SET: assert property (seq_evt_set_write |=>
    (st_q.src & $past(ctrl_wdata_i[15:0]) & FW_EVENT_MASK) == ($past(ctrl_wdata_i[15:0]) & FW_EVENT_MASK))
    else $error("event set lost");
  AST_CLR_LOW: assert property (seq_src_low_write |=>
    (st_q.src[7:0] & $past(clr_lo_sel)) == ZERO_BYTE)
    else $error("permitted low event bit not cleared");
  AST_CLR_KEEP_LOW: assert property (seq_src_low_write |=>
    ($past(keep_lo) & ~st_q.src[7:0]) == ZERO_BYTE)
    else $error("locked low event bit cleared");
  AST_CLR_HIGH: assert property (seq_src_high_write |=>
    (st_q.src[15:8] & $past(clr_hi_sel)) == ZERO_BYTE)
    else $error("permitted high event bit not cleared");
  AST_CLR_KEEP_HIGH: assert property (seq_src_high_write |=>
    ($past(keep_hi) & ~st_q.src[15:8]) == ZERO_BYTE)
    else $error("locked high event bit cleared");
  AST_MBOX_PULSE: assert property (ctrl_mbox_event_o |->
    $past(host_wr_i) && $past(host_addr_i) == HOST_H2C_MBOX)
    else $error("controller event without a mailbox write");
  AST_FLAG_CLEAR: assert property (seq_c2h_host_clear |=> !st_q.src[FLAG_BIT])
    else $error("mailbox written flag not cleared");
  AST_FLAG_SOURCE: assert property ($rose(st_q.src[FLAG_BIT]) |->
    $past(ctrl_wr_i) && $past(ctrl_addr_i) == CTRL_BASE + CTRL_C2H_MBOX)
    else $error("mailbox written flag set without a write");
  AST_C2H_IRQ: assert property (seq_c2h_ctrl_write ##0 st_q.mask_lo[FLAG_BIT]
    ##0 !(host_wr_i && host_addr_i == HOST_MASK_LOW) |=> host_mbox_irq_o)
    else $error("host not notified of mailbox write");
  AST_CLAIM_STABLE: assert property (!(host_wr_i && host_addr_i == HOST_CLAIM_ID) |=>
    $stable(st_q.claim_id))
    else $error("claim changed without a write");
endmodule

// ===== common/hem_pkg.sv
package hem_pkg;
  // ---------------------------------------------------------------
  // host-side offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] HOST_H2C_MBOX    = 8'h00;
  localparam logic [7:0] HOST_C2H_MBOX    = 8'h01;
  localparam logic [7:0] HOST_SRC_LOW     = 8'h08;
  localparam logic [7:0] HOST_SRC_HIGH    = 8'h09;
  localparam logic [7:0] HOST_MASK_LOW    = 8'h0a;
  localparam logic [7:0] HOST_MASK_HIGH   = 8'h0b;
  localparam logic [7:0] HOST_CLAIM_ID    = 8'h0c;
  // ---------------------------------------------------------------
  // controller-side map
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_BASE       = 32'h000f_0100;
  localparam logic [31:0] CTRL_H2C_MBOX   = 32'h0000_0000;
  localparam logic [31:0] CTRL_C2H_MBOX   = 32'h0000_0001;
  localparam logic [31:0] CTRL_W0_BASE    = 32'h0000_0004;
  localparam logic [31:0] CTRL_W0_RLIM    = 32'h0000_0008;
  localparam logic [31:0] CTRL_W0_WLIM    = 32'h0000_000a;
  localparam logic [31:0] CTRL_W1_BASE    = 32'h0000_000c;
  localparam logic [31:0] CTRL_W1_RLIM    = 32'h0000_0010;
  localparam logic [31:0] CTRL_W1_WLIM    = 32'h0000_0012;
  localparam logic [31:0] CTRL_EVT_SET    = 32'h0000_0014;
  localparam logic [31:0] CTRL_CLR_EN     = 32'h0000_0016;
  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  localparam logic [31:0] BASE_MASK       = 32'hffff_fffc;
  localparam logic [15:0] LIMIT_MASK      = 16'h7ffc;
  localparam logic [15:0] FW_EVENT_MASK   = 16'hfffe;
  localparam int          FLAG_BIT        = 0;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;
endpackage

// ===== tb/hem_host_model.sv
module hem_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] host_rdata_i,
  output logic      [7:0] host_addr_o,
  output logic            host_wr_o,
  output logic            host_rd_o,
  output logic      [7:0] host_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------
  // host side: one strobe per access
  // ---------------------------------------------
  initial begin
    host_addr_o = 8'h00;
    host_wr_o = 1'b0;
    host_rd_o = 1'b0;
    host_wdata_o = 8'h00;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    host_addr_o <= a;
    host_wdata_o <= d;
    host_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    host_wr_o <= 1'b0;
    // released data inverted so a stale value never looks valid
    host_wdata_o <= ~d;
    #1;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    host_addr_o <= a;
    host_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    host_rd_o <= 1'b0;
    host_addr_o <= ~a;
    #1;
    d = host_rdata_i;
  endtask
endmodule

// ===== tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hem_pkg::*;
  logic        sys_clk_i, reset_n_i, ctrl_wr_i, ctrl_rd_i;
  logic        host_wr_i, host_rd_i, host_fw_event_irq_o, host_mbox_irq_o, ctrl_mbox_event_o;
  logic [7:0]  host_addr_i, host_wdata_i, host_rdata_o, rd8;
  logic [31:0] ctrl_addr_i, ctrl_wdata_i, ctrl_rdata_o;
  int          n_errors = 0;
  int          comparisons = 0;
  logic [31:0] offs [7] = '{CTRL_W0_BASE, CTRL_W0_RLIM, CTRL_W0_WLIM, CTRL_W1_BASE, CTRL_W1_RLIM,
                            CTRL_W1_WLIM, CTRL_CLR_EN};
  logic [31:0] wv [7] = '{32'h1234_5677, 32'h0000_ffff, 32'h0000_1234, 32'hffff_ffff, 32'h0000_8003,
                          32'h0000_0ffc, 32'h0000_00f0};
  logic [31:0] ev [7] = '{32'h1234_5674, 32'h0000_7ffc, 32'h0000_1234, 32'hffff_fffc, 32'h0000_0000,
                          32'h0000_0ffc, 32'h0000_00f0};
  hem_mailbox hem_mailbox_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .host_addr_i(host_addr_i),
    .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .ctrl_addr_i(ctrl_addr_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_rd_i(ctrl_rd_i), .ctrl_wdata_i(ctrl_wdata_i),
    .ctrl_rdata_o(ctrl_rdata_o), .host_fw_event_irq_o(host_fw_event_irq_o),
    .host_mbox_irq_o(host_mbox_irq_o), .ctrl_mbox_event_o(ctrl_mbox_event_o));
  hem_host_model hem_host_model_inst (.sys_clk_i(sys_clk_i), .host_rdata_i(host_rdata_o),
    .host_addr_o(host_addr_i), .host_wr_o(host_wr_i), .host_rd_o(host_rd_i), .host_wdata_o(host_wdata_i));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hw(input logic [7:0] a, input logic [7:0] d);
    hem_host_model_inst.write(a, d);
  endtask
  task automatic hchk(input logic [7:0] a, input logic [7:0] e);
    hem_host_model_inst.read(a, rd8);
    check(rd8, e);
  endtask
  task automatic cw(input logic [31:0] o, input logic [31:0] d);
    @(posedge sys_clk_i);
    ctrl_addr_i <= CTRL_BASE + o;
    ctrl_wdata_i <= d;
    ctrl_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    ctrl_wr_i <= 1'b0;
    ctrl_wdata_i <= ~d;
    #1;
  endtask
  task automatic cchk(input logic [31:0] o, input logic [31:0] e);
    @(posedge sys_clk_i);
    ctrl_addr_i <= CTRL_BASE + o;
    ctrl_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    ctrl_rd_i <= 1'b0;
    #1;
    check(ctrl_rdata_o, e);
  endtask
  // ---------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    stop_test();
  end
  initial begin
    reset_n_i = 1'b0;
    ctrl_wr_i = 1'b0;
    ctrl_rd_i = 1'b0;
    ctrl_addr_i = 32'h0;
    ctrl_wdata_i = 32'h0;
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    hchk(HOST_MASK_LOW, 8'h00);
    hchk(HOST_SRC_LOW, 8'h00);
    hw(HOST_H2C_MBOX, 8'ha5);
    check(ctrl_mbox_event_o, 1'b1);
    cchk(CTRL_H2C_MBOX, 32'h0000_00a5);
    check(ctrl_mbox_event_o, 1'b0);
    cw(CTRL_H2C_MBOX, 32'h0000_0005);
    hchk(HOST_H2C_MBOX, 8'ha0);
    cchk(32'hffff_ff00, 32'h0);
    // all written before any read, so aliasing between offsets shows
    for (int i = 0; i < 7; i++) cw(offs[i], wv[i]);
    for (int i = 0; i < 7; i++) cchk(offs[i], ev[i]);
    cw(CTRL_C2H_MBOX, 32'h0000_003c);
    check(host_mbox_irq_o, 1'b0);
    hchk(HOST_SRC_LOW, 8'h01);
    hchk(HOST_C2H_MBOX, 8'h3c);
    hw(HOST_MASK_LOW, 8'h01);
    check(host_mbox_irq_o, 1'b1);
    hw(HOST_C2H_MBOX, 8'h00);
    check(host_mbox_irq_o, 1'b0);
    cw(CTRL_C2H_MBOX, 32'h0000_0011);
    check(host_mbox_irq_o, 1'b1);
    hw(HOST_C2H_MBOX, 8'h00);
    cw(CTRL_EVT_SET, 32'h0000_8102);
    check(host_fw_event_irq_o, 1'b0);
    cchk(CTRL_EVT_SET, 32'h0000_8102);
    hw(HOST_MASK_LOW, 8'h03);
    check(host_fw_event_irq_o, 1'b1);
    hw(HOST_MASK_LOW, 8'h01);
    hw(HOST_MASK_HIGH, 8'h80);
    check(host_fw_event_irq_o, 1'b1);
    hw(HOST_MASK_HIGH, 8'h7e);
    check(host_fw_event_irq_o, 1'b0);
    hw(HOST_SRC_LOW, 8'h02);
    hchk(HOST_SRC_LOW, 8'h02);
    cw(CTRL_CLR_EN, 32'h0000_0002);
    hw(HOST_SRC_LOW, 8'h02);
    hchk(HOST_SRC_LOW, 8'h00);
    hw(HOST_SRC_HIGH, 8'h81);
    hchk(HOST_SRC_HIGH, 8'h81);
    cw(CTRL_CLR_EN, 32'h0000_0100);
    hw(HOST_SRC_HIGH, 8'h81);
    hchk(HOST_SRC_HIGH, 8'h80);
    hw(HOST_CLAIM_ID, 8'h5a);
    hchk(HOST_CLAIM_ID, 8'h5a);
    hw(HOST_CLAIM_ID, 8'h33);
    hchk(HOST_CLAIM_ID, 8'h5a);
    hw(HOST_CLAIM_ID, 8'h5a);
    hchk(HOST_CLAIM_ID, 8'h00);
    hw(HOST_CLAIM_ID, 8'h33);
    hchk(HOST_CLAIM_ID, 8'h33);
    hchk(8'h05, 8'h00);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    hchk(HOST_CLAIM_ID, 8'h00);
    hchk(HOST_MASK_HIGH, 8'h00);
    stop_test();
  end
endmodule
